// ---- bit_rate_divider.sv ----
// reloading divider that turns reference ticks into bit-time strobes
`timescale 1ns/1ps
module bit_rate_divider
   import usart_rate_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic tick,
   input wire logic [WIDTH-1:0] reload_value,
   output logic strobe
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic next_strobe;

   // count down per tick, strobe and reload at zero: period is reload+1 ticks
   always_comb
   begin
      next_count = count;
      next_strobe = 1'b0;
      if (!enable)
      begin
         next_count = reload_value; // a fresh latch value takes effect at once
      end
      else if (tick)
      begin
         if (count == '0)
         begin
            next_strobe = 1'b1;
            next_count = reload_value;
         end
         else
         begin
            next_count = count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= '0;
         strobe <= 1'b0;
      end
      else
      begin
         count <= next_count;
         strobe <= next_strobe;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_divider_reload: assert property (strobe |-> $past(tick) && $past(count) == '0)
      else $error("strobe without terminal count");
   chk_divider_counts: assert property (enable && tick && count != '0 |=> count == $past(count) - 1'b1 && !strobe)
      else $error("divider did not step down");
endmodule

// ---- char_shifter.sv ----
// character shifter for both directions, least significant bit first
`timescale 1ns/1ps
module char_shifter
   import usart_rate_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [1:0] word_length,
   input wire logic two_stop,
   input wire logic tx_bit,
   input wire logic tx_load,
   input wire logic [7:0] tx_data,
   output logic tx_busy,
   output logic serial_out_line,
   input wire logic rx_bit,
   input wire logic rx_enable,
   input wire logic serial_in_line,
   output logic rx_done,
   output logic [7:0] rx_data
);
   shift_state_e tx_state, next_tx_state, rx_state, next_rx_state;
   logic [7:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift, next_rx_data;
   logic [2:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt, last_bit;
   logic next_line, next_rx_done;

   // codes 0..3 mean 5..8 data bits
   assign last_bit = SHORTEST_WORD_LAST + {1'b0, word_length};
   assign tx_busy = (tx_state != shift_idle);

   // transmit: start, data bits from bit 0 upward, one or two stop bits
   always_comb
   begin
      next_tx_state = tx_state;
      next_tx_shift = tx_shift;
      next_tx_cnt = tx_cnt;
      next_line = serial_out_line;
      unique case (tx_state)
         shift_idle:
            if (tx_load)
            begin
               next_tx_shift = tx_data;
               next_tx_state = shift_start;
            end
         shift_start:
            if (tx_bit)
            begin
               next_line = 1'b0;
               next_tx_cnt = '0;
               next_tx_state = shift_data;
            end
         shift_data:
            if (tx_bit)
            begin
               next_line = tx_shift[tx_cnt];
               next_tx_cnt = tx_cnt + 1'b1;
               if (tx_cnt == last_bit)
               begin
                  next_tx_cnt = '0;
                  next_tx_state = shift_stop;
               end
            end
         shift_stop:
            if (tx_bit)
            begin
               next_line = 1'b1;
               next_tx_cnt = tx_cnt + 1'b1;
               if (tx_cnt == {2'h0, two_stop})
               begin
                  next_tx_state = shift_idle;
               end
            end
      endcase
   end

   // receive: samples once per bit strobe, no oversampling, framing not checked
   always_comb
   begin
      next_rx_state = rx_state;
      next_rx_shift = rx_shift;
      next_rx_cnt = rx_cnt;
      next_rx_done = 1'b0;
      next_rx_data = rx_data;
      unique case (rx_state)
         shift_idle, shift_start:
            if (rx_bit && !serial_in_line)
            begin
               next_rx_shift = '0; // unused upper bits stay zero
               next_rx_cnt = '0;
               next_rx_state = shift_data;
            end
         shift_data:
            if (rx_bit)
            begin
               next_rx_shift[rx_cnt] = serial_in_line;
               next_rx_cnt = rx_cnt + 1'b1;
               if (rx_cnt == last_bit)
               begin
                  next_rx_state = shift_stop;
               end
            end
         shift_stop:
            if (rx_bit)
            begin
               next_rx_done = 1'b1;
               next_rx_data = rx_shift;
               next_rx_state = shift_idle;
            end
      endcase
      if (!rx_enable)
      begin
         next_rx_state = shift_idle;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_state <= shift_idle;
         tx_shift <= REG_RESET;
         tx_cnt <= '0;
         serial_out_line <= 1'b1;
         rx_state <= shift_idle;
         rx_shift <= REG_RESET;
         rx_cnt <= '0;
         rx_done <= 1'b0;
         rx_data <= REG_RESET;
      end
      else
      begin
         tx_state <= next_tx_state;
         tx_shift <= next_tx_shift;
         tx_cnt <= next_tx_cnt;
         serial_out_line <= next_line;
         rx_state <= next_rx_state;
         rx_shift <= next_rx_shift;
         rx_cnt <= next_rx_cnt;
         rx_done <= next_rx_done;
         rx_data <= next_rx_data;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_rx_zero_fill: assert property (rx_done |-> (rx_data >> (last_bit + 4'h1)) == 8'h00)
      else $error("received upper bits not zero");
   chk_tx_lsb_first: assert property (tx_state == shift_data && tx_cnt == '0 && tx_bit |=> serial_out_line == $past(tx_shift[0]))
      else $error("first data bit is not bit 0");
endmodule

// ---- remote_echo.sv ----
// remote serial device that sends back every bit it hears
`timescale 1ns/1ps
module remote_echo
(
   input wire logic line_from_dut,
   output logic line_to_dut
);
   // echo keeps bit order, so a received byte shows the transmit order
   assign line_to_dut = line_from_dut;
endmodule

// ---- usart_bit_rate_and_buffers.sv ----
// bit-rate generation and buffer registers of the serial port
`timescale 1ns/1ps
module usart_bit_rate_and_buffers
   import usart_rate_pkg::*;
#(
   parameter bit PTG_DIV3_FITTED = 1'b1,
   parameter int DIVIDER_WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic timer_tick,
   input wire logic precision_generator_one_tick,
   input wire logic precision_generator_two_tick,
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic sync_in_clock_pin,
   output logic sync_in_clock_oe,
   output logic sync_out_clock_pin,
   output logic sync_out_clock_oe,
   output logic irq
);
   // software-visible state
   logic [7:0] received_data_buffer, next_received_data_buffer;
   logic [7:0] transmit_data_buffer, next_transmit_data_buffer;
   logic [7:0] serial_interrupt_control, next_serial_interrupt_control;
   logic [7:0] serial_mode_control, next_serial_mode_control;
   logic [7:0] serial_line_control, next_serial_line_control;
   logic [7:0] serial_form_control, next_serial_form_control;
   logic [7:0] out_rate_divider_latch, next_out_rate_divider_latch;
   logic [7:0] in_rate_divider_latch, next_in_rate_divider_latch;
   logic [EVENT_COUNT-1:0] event_status, next_event_status, events, event_enable;
   logic rx_full, next_rx_full, tx_full, next_tx_full, overrun, next_overrun;
   logic [7:0] next_rdata;
   logic next_irq;
   // rate path wiring
   logic [1:0] ptg_tick, bit_strobe, clock_pin, clock_oe, dir_on;
   logic [1:0][DIVIDER_WIDTH-1:0] divider_latch;
   logic sync_mode, timer_ref;
   // shifter wiring
   logic tx_load, tx_busy, rx_done;
   logic [7:0] rx_data;
   logic wr_data, rd_data, wr_clear;
   logic [7:0] status_view;

   assign sync_mode = serial_mode_control[MODE_SYNC_BIT];
   assign timer_ref = serial_mode_control[MODE_TIMER_BIT];
   assign dir_on[DIR_IN] = serial_mode_control[MODE_IN_ON_BIT];
   assign dir_on[DIR_OUT] = serial_mode_control[MODE_OUT_ON_BIT];
   // generators cross over: serial-in runs from two, serial-out from one
   assign ptg_tick[DIR_IN] = precision_generator_two_tick;
   assign ptg_tick[DIR_OUT] = precision_generator_one_tick;
   assign divider_latch[DIR_IN] = in_rate_divider_latch;
   assign divider_latch[DIR_OUT] = out_rate_divider_latch;

   // per direction: optional divide-by-3, reference select, divider, sync halving
   for (genvar d = 0; d < 2; d++)
   begin : g_dir
      logic [1:0] pre_cnt, next_pre_cnt;
      logic pre_tick, next_pre_tick, ref_tick, div_strobe;
      logic pin, next_pin, strobe_q, next_strobe_q, oe, next_oe;

      // the divide-by-3 runs on generator ticks only
      always_comb
      begin
         next_pre_cnt = pre_cnt;
         next_pre_tick = 1'b0;
         if (ptg_tick[d])
         begin
            if (pre_cnt == PTG_PRESCALE_LAST)
            begin
               next_pre_cnt = '0;
               next_pre_tick = 1'b1;
            end
            else
            begin
               next_pre_cnt = pre_cnt + 1'b1;
            end
         end
      end

      // timer ticks already carry the timer latch division: with latch 009b at 6 MHz
      // this is the 38461.54 Hz sync reference
      assign ref_tick = timer_ref ? timer_tick
                      : (PTG_DIV3_FITTED ? pre_tick : ptg_tick[d]);

      bit_rate_divider #(.WIDTH(DIVIDER_WIDTH)) u_div (
         .clk_sys(clk_sys),
         .reset_n(reset_n),
         .enable(dir_on[d]),
         .tick(ref_tick),
         .reload_value(divider_latch[d]),
         .strobe(div_strobe)
      );

      // sync mode toggles the pin per strobe, giving 50% duty and half the rate;
      // the bit strobe falls on the pin's falling edge
      always_comb
      begin
         next_pin = pin;
         next_strobe_q = 1'b0;
         next_oe = sync_mode && dir_on[d];
         if (!sync_mode || !dir_on[d])
         begin
            next_pin = CLOCK_PIN_IDLE;
            next_strobe_q = div_strobe;
         end
         else if (div_strobe)
         begin
            next_pin = !pin;
            next_strobe_q = pin;
         end
      end

      always_ff @(posedge clk_sys or negedge reset_n)
      begin
         if (!reset_n)
         begin
            pre_cnt <= '0;
            pre_tick <= 1'b0;
            pin <= CLOCK_PIN_IDLE;
            strobe_q <= 1'b0;
            oe <= 1'b0;
         end
         else
         begin
            pre_cnt <= next_pre_cnt;
            pre_tick <= next_pre_tick;
            pin <= next_pin;
            strobe_q <= next_strobe_q;
            oe <= next_oe;
         end
      end

      assign bit_strobe[d] = strobe_q;
      assign clock_pin[d] = pin;
      assign clock_oe[d] = oe;
   end

   assign sync_in_clock_pin = clock_pin[DIR_IN];
   assign sync_out_clock_pin = clock_pin[DIR_OUT];
   assign sync_in_clock_oe = clock_oe[DIR_IN];
   assign sync_out_clock_oe = clock_oe[DIR_OUT];

   // shifter takes the buffer as soon as it is idle with serial-out on, freeing the buffer for the next byte
   assign tx_load = tx_full && !tx_busy && dir_on[DIR_OUT];

   char_shifter u_shift (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .word_length(serial_line_control[LINE_WORD_LOW_BIT +: 2]),
      .two_stop(serial_line_control[LINE_TWO_STOP_BIT]),
      .tx_bit(bit_strobe[DIR_OUT]),
      .tx_load(tx_load),
      .tx_data(transmit_data_buffer),
      .tx_busy(tx_busy),
      .serial_out_line(serial_out_line),
      .rx_bit(bit_strobe[DIR_IN]),
      .rx_enable(dir_on[DIR_IN]),
      .serial_in_line(serial_in_line),
      .rx_done(rx_done),
      .rx_data(rx_data)
   );

   // bus decode
   assign wr_data = reg_write && reg_addr == DATA_BUFFER_ADDR;
   assign rd_data = reg_read && reg_addr == DATA_BUFFER_ADDR;
   assign wr_clear = reg_write && reg_addr == EVENT_CLEAR_ADDR;
   assign status_view = (8'(rx_full) << STATUS_RX_FULL_BIT)
                      | (8'(overrun) << STATUS_OVERRUN_BIT)
                      | (8'(!tx_full) << STATUS_TX_EMPTY_BIT);
   assign events[EVENT_RX_FULL] = rx_done;
   assign events[EVENT_TX_EMPTY] = tx_load;
   assign events[EVENT_OVERRUN] = rx_done && rx_full && !rd_data;
   assign event_enable = serial_interrupt_control[EVENT_COUNT-1:0];

   // register writes and buffer flags; hardware sets win over software clears
   always_comb
   begin
      next_received_data_buffer = received_data_buffer;
      next_transmit_data_buffer = transmit_data_buffer;
      next_serial_interrupt_control = serial_interrupt_control;
      next_serial_mode_control = serial_mode_control;
      next_serial_line_control = serial_line_control;
      next_serial_form_control = serial_form_control;
      next_out_rate_divider_latch = out_rate_divider_latch;
      next_in_rate_divider_latch = in_rate_divider_latch;
      next_rx_full = (rx_full && !rd_data) || rx_done;
      next_tx_full = (tx_full && !tx_load) || wr_data;
      next_overrun = overrun;
      if (reg_read && reg_addr == STATUS_ADDR)
      begin
         next_overrun = 1'b0;
      end
      if (events[EVENT_OVERRUN])
      begin
         next_overrun = 1'b1;
      end
      if (rx_done)
      begin
         next_received_data_buffer = rx_data;
      end
      next_event_status = event_status;
      if (wr_clear)
      begin
         next_event_status = event_status & ~reg_wdata[EVENT_COUNT-1:0];
      end
      next_event_status = next_event_status | events;
      if (reg_write)
      begin
         unique case (reg_addr)
            DATA_BUFFER_ADDR: next_transmit_data_buffer = reg_wdata;
            INT_CONTROL_ADDR: next_serial_interrupt_control = reg_wdata;
            MODE_ADDR: next_serial_mode_control = reg_wdata;
            LINE_ADDR: next_serial_line_control = reg_wdata;
            FORM_ADDR: next_serial_form_control = reg_wdata;
            OUT_DIVIDER_ADDR: next_out_rate_divider_latch = reg_wdata;
            IN_DIVIDER_ADDR: next_in_rate_divider_latch = reg_wdata;
            default: ;
         endcase
      end
   end

   // read mux, answered in the next cycle; latches and clear register read zero
   always_comb
   begin
      next_rdata = REG_RESET;
      if (reg_read)
      begin
         unique case (reg_addr)
            DATA_BUFFER_ADDR: next_rdata = received_data_buffer;
            INT_CONTROL_ADDR: next_rdata = serial_interrupt_control;
            MODE_ADDR: next_rdata = serial_mode_control;
            LINE_ADDR: next_rdata = serial_line_control;
            STATUS_ADDR: next_rdata = status_view;
            FORM_ADDR: next_rdata = serial_form_control;
            EVENT_STATUS_ADDR: next_rdata = {5'h00, event_status};
            default: next_rdata = REG_RESET;
         endcase
      end
      next_irq = |(next_event_status & event_enable);
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         received_data_buffer <= REG_RESET;
         transmit_data_buffer <= REG_RESET;
         serial_interrupt_control <= REG_RESET;
         serial_mode_control <= REG_RESET;
         serial_line_control <= REG_RESET;
         serial_form_control <= REG_RESET;
         out_rate_divider_latch <= REG_RESET;
         in_rate_divider_latch <= REG_RESET;
         event_status <= EVENT_RESET;
         rx_full <= 1'b0;
         tx_full <= 1'b0;
         overrun <= 1'b0;
         reg_rdata <= REG_RESET;
         irq <= 1'b0;
      end
      else
      begin
         received_data_buffer <= next_received_data_buffer;
         transmit_data_buffer <= next_transmit_data_buffer;
         serial_interrupt_control <= next_serial_interrupt_control;
         serial_mode_control <= next_serial_mode_control;
         serial_line_control <= next_serial_line_control;
         serial_form_control <= next_serial_form_control;
         out_rate_divider_latch <= next_out_rate_divider_latch;
         in_rate_divider_latch <= next_in_rate_divider_latch;
         event_status <= next_event_status;
         rx_full <= next_rx_full;
         tx_full <= next_tx_full;
         overrun <= next_overrun;
         reg_rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_data_read_answer: assert property (rd_data |=> reg_rdata == $past(received_data_buffer))
      else $error("data read did not return received buffer");
   chk_data_write_load: assert property (wr_data |=> tx_full && transmit_data_buffer == $past(reg_wdata))
      else $error("data write did not load transmit buffer");
   chk_gen_crossover: assert property (!timer_ref |-> (!g_dir[DIR_IN].ref_tick || (PTG_DIV3_FITTED ? $past(precision_generator_two_tick) : precision_generator_two_tick)) && (!g_dir[DIR_OUT].ref_tick || (PTG_DIV3_FITTED ? $past(precision_generator_one_tick) : precision_generator_one_tick)))
      else $error("generator crossover broken");
   chk_timer_select: assert property (timer_ref |-> g_dir[DIR_IN].ref_tick == timer_tick && g_dir[DIR_OUT].ref_tick == timer_tick)
      else $error("timer reference not used by both directions");
   chk_prescale_three: assert property (g_dir[DIR_IN].pre_tick |-> $past(ptg_tick[DIR_IN]) && $past(g_dir[DIR_IN].pre_cnt) == PTG_PRESCALE_LAST)
      else $error("divide-by-3 ticked early");
   chk_sync_half_rate: assert property (sync_mode && dir_on[DIR_OUT] && $past(sync_mode && dir_on[DIR_OUT]) && bit_strobe[DIR_OUT] |-> $past(clock_pin[DIR_OUT]) && !clock_pin[DIR_OUT])
      else $error("sync bit strobe not on falling clock");
   chk_pin_drive: assert property (##1 clock_oe[DIR_IN] == $past(sync_mode && dir_on[DIR_IN]))
      else $error("clock pin enable does not follow sync mode");
   chk_irq_level: assert property (irq == |(event_status & $past(event_enable)))
      else $error("interrupt level wrong");
   chk_set_wins: assert property (rx_done && wr_clear && reg_wdata[EVENT_RX_FULL] |=> event_status[EVENT_RX_FULL])
      else $error("event lost under clear");
   chk_rx_full_set: assert property (rx_done |=> rx_full && received_data_buffer == $past(rx_data))
      else $error("received byte not buffered");

   cov_sync_transfer: cover property (sync_mode && tx_load ##[1:300] !tx_busy);
   cov_generator_rx: cover property (!timer_ref && rx_done);
   cov_overrun: cover property (events[EVENT_OVERRUN]);
   cov_irq: cover property ($rose(irq));
endmodule

// ---- usart_bit_rate_and_buffers_tb_top.sv ----
// testbench for the serial bit-rate and buffer block
`timescale 1ns/1ps
module usart_bit_rate_and_buffers_tb_top;
   import usart_rate_pkg::*;
   logic clk_sys = 0, reset_n = 0, reg_write = 0, reg_read = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [1:0] ph = 0;
   logic sin, sout, ci, cio, co, coe, irq;
   int fail_count = 0, checked = 0;
   logic [7:0] md [6] = '{8'he0, 8'hf0, 8'hc0, 8'hd0, 8'he0, 8'hc0};
   logic [7:0] dat [6] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'hff, 8'he7};
   initial forever #2.5 clk_sys = ~clk_sys;
   // staggered reference ticks, one each per four cycles, keep frames short
   always @(posedge clk_sys) ph <= ph + 2'h1;
   usart_bit_rate_and_buffers dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .timer_tick(ph == 2'h0),
      .precision_generator_one_tick(ph == 2'h1), .precision_generator_two_tick(ph == 2'h2),
      .serial_in_line(sin), .serial_out_line(sout), .sync_in_clock_pin(ci),
      .sync_in_clock_oe(cio), .sync_out_clock_pin(co), .sync_out_clock_oe(coe), .irq);
   remote_echo echo (.line_from_dut(sout), .line_to_dut(sin));
   task automatic cmp(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe, so look there
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 cmp("reg_rdata", reg_rdata, e);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // bounded wait for the interrupt; a frame at the slowest mode is under 1400 cycles
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 4000)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 4000)
      begin
         fail_count++;
         report_and_stop();
      end
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(STATUS_ADDR, 8'h20);
      rd(OUT_DIVIDER_ADDR, 8'h00);
      rd(8'h50, 8'h00);
      wr(OUT_DIVIDER_ADDR, 8'h01);
      wr(IN_DIVIDER_ADDR, 8'h01);
      wr(INT_CONTROL_ADDR, 8'h01);
      // every timing reference in both modes, then five-bit words on timer and generators
      for (int i = 0; i < 6; i++)
      begin
         wr(MODE_ADDR, 8'h00);
         // five-bit words: zero for the timer, fifteen for the generators
         if (i >= 4)
         begin
            wr(OUT_DIVIDER_ADDR, (i == 4) ? 8'h00 : 8'h0f);
            wr(IN_DIVIDER_ADDR, (i == 4) ? 8'h00 : 8'h0f);
         end
         // no parity here, so set upper transmit bits are allowed
         wr(LINE_ADDR, (i >= 4) ? 8'h00 : 8'h03);
         wr(MODE_ADDR, md[i]);
         wr(DATA_BUFFER_ADDR, dat[i]);
         wait_irq();
         cmp("sync_in_clock_oe", {7'h0, cio}, {7'h0, md[i][MODE_SYNC_BIT]});
         cmp("sync_out_clock_oe", {7'h0, coe}, {7'h0, md[i][MODE_SYNC_BIT]});
         rd(EVENT_STATUS_ADDR, 8'h03);
         rd(DATA_BUFFER_ADDR, (i >= 4) ? (dat[i] & 8'h1f) : dat[i]);
         rd(STATUS_ADDR, 8'h20);
         wr(EVENT_CLEAR_ADDR, 8'h07);
         rd(EVENT_STATUS_ADDR, 8'h00);
         cmp("irq", {7'h0, irq}, 8'h00);
      end
      // last mode is asynchronous, so both clock pins rest idle
      cmp("sync_in_clock_pin", {7'h0, ci}, 8'h01);
      cmp("sync_out_clock_pin", {7'h0, co}, 8'h01);
      report_and_stop();
   end
endmodule

// ---- usart_rate_pkg.sv ----
// constants and types shared by the serial bit-rate and buffer block
// What this block does
// - with generators selected, serial-in uses generator two, serial-out generator one
// - async timer rate is timer clock over (timer latch+1)(divider latch+1)
// - sync timer use adds divide-by-two, giving a 50% duty clock pin
// - async generator rate is generator rate over 3(divider latch+1) with option fitted
// - sync generator use adds divide-by-two: generator rate over 6(divider latch+1)
// - one shared data address: read gives received buffer, write loads transmit buffer
// - every character is shifted least significant bit first in both directions
// - for short words the received buffer has its unused upper bits zero
// - timer latch 009b at 6 MHz gives the 38461.54 Hz sync reference
// - mode timing bit set selects the timer for both, clear selects generators
// - word length codes zero to three mean five to eight data bits
// - mode sync bit selects sync operation and drives the clock pin of each enabled direction
package usart_rate_pkg;
   // register offsets
   localparam logic [7:0] DATA_BUFFER_ADDR = 8'h38;
   localparam logic [7:0] INT_CONTROL_ADDR = 8'h39;
   localparam logic [7:0] MODE_ADDR = 8'h3a;
   localparam logic [7:0] LINE_ADDR = 8'h3b;
   localparam logic [7:0] STATUS_ADDR = 8'h3c;
   localparam logic [7:0] FORM_ADDR = 8'h3d;
   localparam logic [7:0] OUT_DIVIDER_ADDR = 8'h3e;
   localparam logic [7:0] IN_DIVIDER_ADDR = 8'h3f;
   localparam logic [7:0] EVENT_STATUS_ADDR = 8'h40;
   localparam logic [7:0] EVENT_CLEAR_ADDR = 8'h41;
   // mode register fields
   localparam int MODE_SYNC_BIT = 4;
   localparam int MODE_TIMER_BIT = 5;
   localparam int MODE_OUT_ON_BIT = 6;
   localparam int MODE_IN_ON_BIT = 7;
   // line control fields
   localparam int LINE_WORD_LOW_BIT = 0;
   localparam int LINE_TWO_STOP_BIT = 2;
   // serial status fields
   localparam int STATUS_RX_FULL_BIT = 0;
   localparam int STATUS_OVERRUN_BIT = 1;
   localparam int STATUS_TX_EMPTY_BIT = 5;
   // event bits, shared by event status, clear and the enable bits of interrupt control
   localparam int EVENT_RX_FULL = 0;
   localparam int EVENT_TX_EMPTY = 1;
   localparam int EVENT_OVERRUN = 2;
   localparam int EVENT_COUNT = 3;
   // reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [EVENT_COUNT-1:0] EVENT_RESET = 3'h0;
   localparam logic CLOCK_PIN_IDLE = 1'b1;
   // timing
   localparam logic [1:0] PTG_PRESCALE_LAST = 2'h2;
   localparam logic [2:0] SHORTEST_WORD_LAST = 3'h4;
   localparam logic [15:0] SYNC_TIMER_LATCH = 16'h009b;
   // direction indices
   localparam int DIR_IN = 0;
   localparam int DIR_OUT = 1;
   typedef enum logic [1:0] {shift_idle, shift_start, shift_data, shift_stop} shift_state_e;
endpackage
